/* File: rtl/wdt_consts.vh */
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define WDT_MODE_OFS 12'h000
`define WDT_RELOAD_OFS 12'h004
`define WDT_FEED_OFS 12'h008
`define WDT_COUNT_OFS 12'h00c
`define WDT_WARN_OFS 12'h010
`define WDT_WINDOW_OFS 12'h014
`define WDT_STATUS_OFS 12'h018
`define WDT_CLEAR_OFS 12'h01c
`define WDT_IRQEN_OFS 12'h020
`define WDT_CAUSE_OFS 12'h024

// ************************************************************
// mode register fields
// ************************************************************
`define WDT_MODE_EN_BIT 0
`define WDT_MODE_RSTEN_BIT 1

// ************************************************************
// status, clear and enable fields
// ************************************************************
`define WDT_EV_TIMEOUT_BIT 0
`define WDT_EV_WARN_BIT 1
`define WDT_EV_BADFEED_BIT 2
`define WDT_EV_W 3

// ************************************************************
// feed sequence values
// ************************************************************
`define WDT_FEED_FIRST 8'haa
`define WDT_FEED_SECOND 8'h55

// ************************************************************
// widths, limits and reset values
// ************************************************************
`define WDT_CNT_W 24
`define WDT_RELOAD_MIN 24'h0000ff
`define WDT_RELOAD_RST 24'h0000ff
`define WDT_WARN_RST 24'h000000
`define WDT_WINDOW_RST 24'hffffff
`define WDT_PRESCALE 3'h4

`endif

/* File: rtl/tick_prescaler.v */
`include "wdt_consts.vh"

// ************************************************************
// divide watchdog ticks by four
// ************************************************************
module tick_prescaler (
  input wire core_clk,
  input wire srst,
  input wire tick_in,
  output reg tick_out
);

  reg [2:0] div_cnt;

  always @(posedge core_clk) begin
    if (srst) begin
      div_cnt <= 3'h0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (div_cnt == `WDT_PRESCALE - 3'h1) begin
          div_cnt <= 3'h0;
          tick_out <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 3'h1;
        end
      end
    end
  end

endmodule

/* File: rtl/windowed_watchdog_timer.v */
// Our own choices: the register offsets and the APB register port.
`include "wdt_consts.vh"

// What this block does
// R1 - time-out without reload resets the chip when the reset enable bit is set
// R2 - windowed mode accepts reloads only inside window
// R3 - optional warning interrupt before time-out
// R4 - enable set by software, cleared by reset
// R5 - bad feed gives reset or interrupt
// R6 - reset-cause flag survives watchdog reset
// R7 - 24-bit counter through divide-by-four prescaler
// R8 - time-out range 256 to 2^24 counts
// R9 - timing runs only on watchdog ticks
// R10 - feed is ordered pair of fixed writes
module windowed_watchdog_timer (
  input wire core_clk,
  input wire srst,
  input wire power_on_rst,
  input wire watchdog_tick_clock,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  output reg chip_reset_req,
  output wire irq
);

  // ************************************************************
  // registers
  // ************************************************************
  reg wd_enable;
  reg reset_enable;
  reg [`WDT_CNT_W-1:0] reload_value;
  reg [`WDT_CNT_W-1:0] warn_value;
  reg [`WDT_CNT_W-1:0] window_value;
  reg [`WDT_CNT_W-1:0] count;
  reg [`WDT_EV_W-1:0] status;
  reg [`WDT_EV_W-1:0] irq_enable;
  reg reset_cause;
  localparam [1:0] feed_wait_first = 2'h1;
  localparam [1:0] feed_wait_second = 2'h2;
  reg [1:0] feed_state;
  reg [1:0] next_feed_state;

  wire prescaled_tick;
  wire access;
  wire setup;
  reg addr_ok;
  wire feed_armed;
  reg [31:0] next_rdata;
  reg feed_ok;
  reg feed_bad;
  wire in_window;
  wire timeout_ev;
  wire warn_ev;
  wire [`WDT_EV_W-1:0] events;
  wire [`WDT_EV_W-1:0] clear_bits;
  wire fault_ev;
  wire [`WDT_CNT_W-1:0] reload_clip;

  assign pready = 1'b1;
  assign setup = psel & ~penable;
  assign access = psel & penable;

  // ************************************************************
  // address decode
  // ************************************************************
  // unmapped offsets answer with a slave error
  always @* begin
    addr_ok = 1'b0;
    if (paddr == `WDT_MODE_OFS) begin
      addr_ok = 1'b1;
    end else if (paddr == `WDT_RELOAD_OFS) begin
      addr_ok = 1'b1;
    end else if (paddr == `WDT_FEED_OFS) begin
      addr_ok = 1'b1;
    end else if (paddr == `WDT_COUNT_OFS) begin
      addr_ok = 1'b1;
    end else if (paddr == `WDT_WARN_OFS) begin
      addr_ok = 1'b1;
    end else if (paddr == `WDT_WINDOW_OFS) begin
      addr_ok = 1'b1;
    end else if (paddr == `WDT_STATUS_OFS) begin
      addr_ok = 1'b1;
    end else if (paddr == `WDT_CLEAR_OFS) begin
      addr_ok = 1'b1;
    end else if (paddr == `WDT_IRQEN_OFS) begin
      addr_ok = 1'b1;
    end else if (paddr == `WDT_CAUSE_OFS) begin
      addr_ok = 1'b1;
    end
  end

  // ************************************************************
  // prescaler
  // ************************************************************
  // R7 divide by four
  // R9 tick-only timing
  tick_prescaler u_prescaler (
    .core_clk(core_clk),
    .srst(srst),
    .tick_in(watchdog_tick_clock),
    .tick_out(prescaled_tick)
  );

  // ************************************************************
  // feed sequence decode
  // ************************************************************
  // R2 window check
  assign in_window = (count <= window_value);

  // R10 ordered feed pair
  always @* begin
    feed_ok = 1'b0;
    feed_bad = 1'b0;
    if (access && feed_armed) begin
      if (pwrite && paddr == `WDT_FEED_OFS && pwdata[7:0] == `WDT_FEED_SECOND) begin
        // R5 early feed is a fault
        if (wd_enable && !in_window) begin
          feed_bad = 1'b1;
        end else begin
          feed_ok = 1'b1;
        end
      end else begin
        // R5 broken sequence
        feed_bad = wd_enable;
      end
    end
  end

  // first feed word arms the pair
  always @* begin
    next_feed_state = feed_state;
    case (feed_state)
      feed_wait_first: begin
        if (access && pwrite && paddr == `WDT_FEED_OFS &&
            pwdata[7:0] == `WDT_FEED_FIRST) begin
          next_feed_state = feed_wait_second;
        end
      end
      feed_wait_second: begin
        // any access ends the pair, good or bad
        if (access) begin
          next_feed_state = feed_wait_first;
        end
      end
      default: begin
        next_feed_state = feed_wait_first;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (srst) begin
      feed_state <= feed_wait_first;
    end else begin
      feed_state <= next_feed_state;
    end
  end

  assign feed_armed = (feed_state == feed_wait_second);

  // ************************************************************
  // counter
  // ************************************************************
  // R8 at least 256 counts
  assign reload_clip = (pwdata[23:0] < `WDT_RELOAD_MIN) ? `WDT_RELOAD_MIN : pwdata[23:0];

  // R1 expiry
  assign timeout_ev = wd_enable && prescaled_tick && count == {`WDT_CNT_W{1'b0}};
  // R3 warning point
  assign warn_ev = wd_enable && prescaled_tick && count == warn_value &&
                   count != {`WDT_CNT_W{1'b0}};
  assign fault_ev = timeout_ev | feed_bad;

  always @(posedge core_clk) begin
    if (srst) begin
      count <= `WDT_RELOAD_RST;
    end else if (feed_ok) begin
      count <= reload_value;
    end else if (wd_enable && prescaled_tick && count != {`WDT_CNT_W{1'b0}}) begin
      // R7 24-bit decrement
      count <= count - {{(`WDT_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  always @(posedge core_clk) begin
    if (srst) begin
      wd_enable <= 1'b0;
      reset_enable <= 1'b0;
      reload_value <= `WDT_RELOAD_RST;
      warn_value <= `WDT_WARN_RST;
      window_value <= `WDT_WINDOW_RST;
      irq_enable <= {`WDT_EV_W{1'b0}};
    end else begin
      if (access && pwrite) begin
        if (paddr == `WDT_MODE_OFS) begin
          // R4 set only
          if (pwdata[`WDT_MODE_EN_BIT]) begin
            wd_enable <= 1'b1;
          end
          if (!wd_enable) begin
            reset_enable <= pwdata[`WDT_MODE_RSTEN_BIT];
          end
        end else if (paddr == `WDT_RELOAD_OFS) begin
          reload_value <= reload_clip;
        end else if (paddr == `WDT_WARN_OFS) begin
          warn_value <= pwdata[23:0];
        end else if (paddr == `WDT_WINDOW_OFS) begin
          window_value <= pwdata[23:0];
        end else if (paddr == `WDT_IRQEN_OFS) begin
          irq_enable <= pwdata[`WDT_EV_W-1:0];
        end
      end
      // R4 cleared by watchdog action
      if (fault_ev) begin
        wd_enable <= 1'b0;
      end
    end
  end

  // ************************************************************
  // reset request and cause flag
  // ************************************************************
  always @(posedge core_clk) begin
    if (srst) begin
      chip_reset_req <= 1'b0;
    end else begin
      // R1 chip reset
      // R5 reset on bad feed
      chip_reset_req <= fault_ev && reset_enable;
    end
  end

  // only power-on or a write of 1 to bit 0 of the cause register clears it, so it outlives the watchdog reset
  always @(posedge core_clk) begin
    if (power_on_rst) begin
      reset_cause <= 1'b0;
    end else if (fault_ev && reset_enable) begin
      // R6 cause flag
      reset_cause <= 1'b1;
    end else if (access && pwrite && paddr == `WDT_CAUSE_OFS && pwdata[0]) begin
      reset_cause <= 1'b0;
    end
  end

  // ************************************************************
  // interrupt status
  // ************************************************************
  assign events[`WDT_EV_TIMEOUT_BIT] = timeout_ev;
  assign events[`WDT_EV_WARN_BIT] = warn_ev;
  assign events[`WDT_EV_BADFEED_BIT] = feed_bad;
  assign clear_bits = (access && pwrite && paddr == `WDT_CLEAR_OFS) ?
                      pwdata[`WDT_EV_W-1:0] : {`WDT_EV_W{1'b0}};

  genvar gi;
  generate
    for (gi = 0; gi < `WDT_EV_W; gi = gi + 1) begin : g_status
      always @(posedge core_clk) begin
        if (srst) begin
          status[gi] <= 1'b0;
        end else if (events[gi]) begin
          // R3 warning flag, with the R1 time-out and R5 bad-feed flags
          status[gi] <= 1'b1;
        end else if (clear_bits[gi]) begin
          status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(status & irq_enable);

  // ************************************************************
  // read data
  // ************************************************************
  always @* begin
    next_rdata = 32'h0000_0000;
    if (paddr == `WDT_MODE_OFS) begin
      next_rdata[`WDT_MODE_EN_BIT] = wd_enable;
      next_rdata[`WDT_MODE_RSTEN_BIT] = reset_enable;
    end else if (paddr == `WDT_RELOAD_OFS) begin
      next_rdata[23:0] = reload_value;
    end else if (paddr == `WDT_COUNT_OFS) begin
      next_rdata[23:0] = count;
    end else if (paddr == `WDT_WARN_OFS) begin
      next_rdata[23:0] = warn_value;
    end else if (paddr == `WDT_WINDOW_OFS) begin
      next_rdata[23:0] = window_value;
    end else if (paddr == `WDT_STATUS_OFS) begin
      next_rdata[`WDT_EV_W-1:0] = status;
    end else if (paddr == `WDT_IRQEN_OFS) begin
      next_rdata[`WDT_EV_W-1:0] = irq_enable;
    end else if (paddr == `WDT_CAUSE_OFS) begin
      next_rdata[0] = reset_cause;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= ~addr_ok;
    end
  end

endmodule

/* File: tb/wdt_props.sv */
// ************************************************************
// port checker
// ************************************************************
module wdt_props (
  input wire core_clk,
  input wire srst,
  input wire power_on_rst,
  input wire watchdog_tick_clock,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire chip_reset_req,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  pready_high_a: assert property (pready)
    else $error("pready low");
  req_pulse_a: assert property (chip_reset_req |=> !chip_reset_req)
    else $error("reset request longer than one cycle");
  rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data changed outside setup");
  err_hold_a: assert property (!(psel && !penable) |=> $stable(pslverr))
    else $error("slave error changed outside setup");
  unmapped_err_a: assert property (psel && !penable && paddr > 12'h024 |=>
    pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && !penable && paddr <= 12'h024 &&
    paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  err_cause_a: assert property ($rose(pslverr) |-> $past(psel && !penable))
    else $error("slave error without setup");
  irq_fall_a: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
    else $error("interrupt dropped without a register write");
  write_rdata_a: assert property (psel && !penable && pwrite |=> prdata == 32'h0)
    else $error("read data not zero on write");
  reset_quiet_a: assert property (disable iff (1'b0) srst |=>
    !chip_reset_req && !irq && prdata == 32'h0)
    else $error("outputs active after reset");
endmodule

/* File: tb/tb_top.sv */
`include "wdt_consts.vh"
// ************************************************************
// bench
// ************************************************************
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, srst = 1, power_on_rst = 1, watchdog_tick_clock = 0;
  logic psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  wire pready, pslverr, chip_reset_req, irq;
  wire [31:0] prdata;
  int fails = 0, total_checks = 0, pulses = 0, i;
  logic [44:0] rows [9];
  windowed_watchdog_timer windowed_watchdog_timer_i (.core_clk(core_clk), .srst(srst),
    .power_on_rst(power_on_rst), .watchdog_tick_clock(watchdog_tick_clock), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .chip_reset_req(chip_reset_req), .irq(irq));
  initial forever #50 core_clk = ~core_clk;
  // one tick pulse every second cycle
  always @(posedge core_clk) watchdog_tick_clock <= ~watchdog_tick_clock;
  always @(posedge core_clk) if (chip_reset_req === 1'b1) pulses++;
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk) penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge core_clk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic waitirq;
    for (i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge core_clk);
  endtask
  initial begin
    rows = '{{1'b0, `WDT_MODE_OFS, 32'h0}, {1'b0, `WDT_RELOAD_OFS, 32'hff},
      {1'b0, `WDT_COUNT_OFS, 32'hff}, {1'b0, `WDT_WARN_OFS, 32'h0},
      {1'b0, `WDT_WINDOW_OFS, 32'hffffff}, {1'b0, `WDT_STATUS_OFS, 32'h0},
      {1'b0, `WDT_IRQEN_OFS, 32'h0}, {1'b0, `WDT_CAUSE_OFS, 32'h0}, {1'b1, 12'h100, 32'h0}};
    repeat (12) @(posedge core_clk);
    srst <= 0;
    power_on_rst <= 0;
    for (int r = 0; r < 9; r++) begin
      apb(0, rows[r][43:32], 32'h0);
      chk("reset value", rows[r][31:0], rd);
      chk("slave error", {31'h0, rows[r][44]}, {31'h0, er});
    end
    apb(1, `WDT_WARN_OFS, 32'h80);
    apb(1, `WDT_IRQEN_OFS, 32'h2);
    apb(1, `WDT_MODE_OFS, 32'h1);
    apb(1, `WDT_MODE_OFS, 32'h0);
    rdchk("enable set-only", `WDT_MODE_OFS, 32'h1);
    waitirq();
    rdchk("warning status", `WDT_STATUS_OFS, 32'h2);
    apb(1, `WDT_IRQEN_OFS, 32'h0);
    chk("irq masked", 32'h0, irq);
    apb(1, `WDT_IRQEN_OFS, 32'h1);
    apb(1, `WDT_FEED_OFS, 32'haa);
    apb(1, `WDT_FEED_OFS, 32'h55);
    apb(0, `WDT_COUNT_OFS, 32'h0);
    chk("reloaded count", 32'h1, rd >= 32'hfe);
    waitirq();
    // 256 counts of four ticks, a tick every two cycles
    chk("timeout span", 32'h1, i > 2000 && i < 2100);
    rdchk("timeout status", `WDT_STATUS_OFS, 32'h3);
    chk("no reset request", 32'h0, pulses);
    rdchk("enable cleared", `WDT_MODE_OFS, 32'h0);
    apb(1, `WDT_CLEAR_OFS, 32'h7);
    rdchk("status cleared", `WDT_STATUS_OFS, 32'h0);
    chk("irq cleared", 32'h0, irq);
    apb(1, `WDT_FEED_OFS, 32'haa);
    apb(1, `WDT_FEED_OFS, 32'h55);
    apb(1, `WDT_MODE_OFS, 32'h3);
    apb(1, `WDT_FEED_OFS, 32'haa);
    apb(0, `WDT_STATUS_OFS, 32'h0);
    rdchk("bad feed status", `WDT_STATUS_OFS, 32'h4);
    chk("one reset request", 32'h1, pulses);
    rdchk("cause set", `WDT_CAUSE_OFS, 32'h1);
    srst <= 1;
    repeat (2) @(posedge core_clk);
    srst <= 0;
    rdchk("cause kept", `WDT_CAUSE_OFS, 32'h1);
    rdchk("status reset", `WDT_STATUS_OFS, 32'h0);
    power_on_rst <= 1;
    @(posedge core_clk) power_on_rst <= 0;
    rdchk("cause power-on", `WDT_CAUSE_OFS, 32'h0);
    apb(1, `WDT_WINDOW_OFS, 32'h10);
    apb(1, `WDT_MODE_OFS, 32'h1);
    apb(1, `WDT_FEED_OFS, 32'haa);
    apb(1, `WDT_FEED_OFS, 32'h55);
    rdchk("early feed", `WDT_STATUS_OFS, 32'h4);
    apb(1, `WDT_RELOAD_OFS, 32'h10);
    rdchk("reload floor", `WDT_RELOAD_OFS, 32'hff);
    apb(1, `WDT_CLEAR_OFS, 32'h7);
    apb(1, `WDT_WINDOW_OFS, 32'hf0);
    apb(1, `WDT_MODE_OFS, 32'h3);
    // let the count fall below the window
    repeat (200) @(posedge core_clk);
    apb(1, `WDT_FEED_OFS, 32'haa);
    apb(1, `WDT_FEED_OFS, 32'h55);
    rdchk("late feed status", `WDT_STATUS_OFS, 32'h0);
    apb(0, `WDT_COUNT_OFS, 32'h0);
    chk("late feed reload", 32'h1, rd >= 32'hfe);
    for (i = 0; i < 4000 && pulses < 2; i++) @(posedge core_clk);
    chk("timeout reset", 32'h2, pulses);
    rdchk("timeout reset status", `WDT_STATUS_OFS, 32'h1);
    wrap_up();
  end
  initial begin
    #1000000;
    fails++;
    wrap_up();
  end
endmodule
bind windowed_watchdog_timer wdt_props wdt_props_i (.core_clk(core_clk), .srst(srst),
  .power_on_rst(power_on_rst), .watchdog_tick_clock(watchdog_tick_clock), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .chip_reset_req(chip_reset_req), .irq(irq));
